// >>> hw/srap_i2c_target.sv
// Operation
// [RL1] Answer only the seven-bit target address
// [RL2] Oversampled edges work at standard and fast
// [RL3] First written byte is command, rest data
// [RL4] Repeated start reads the just selected register
// [RL5] Bare read uses pointer from last command
// [RL6] Clear top bit: byte is data at pointer
// [RL7] Command carries action or five-bit pointer
// [RL8] Command actions clear pending interrupts
// [RL9] Host selects register before accessing it
// [RL10] Host sets bit seven on command bytes
// [RL11] Thresholds stored as low/high byte pairs
// [RL12] Read-only result bytes, zero after reset
// [RL13] Function enable resets to zero
// [RL14] Host should load ambient time with FF
// [RL15] Type 00 repeats, 01 auto-increments pointer
// [RL16] Special code 00101 pulses interrupt clear
module srap_i2c_target import srap_pkg::*; (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [15:0] prox_result,
    input wire logic prox_result_valid,
    input wire logic [7:0] device_status,
    output logic [7:0] function_enable,
    output logic [7:0] ambient_conversion_time,
    output logic [7:0] prox_conversion_time,
    output logic [7:0] idle_period_length,
    output logic [15:0] prox_lower_limit,
    output logic [15:0] prox_upper_limit,
    output logic [7:0] interrupt_persistence_filter,
    output logic [7:0] device_configuration,
    output logic [7:0] led_pulse_count,
    output logic [7:0] drive_control,
    output logic prox_int_clear
);

    // ****************************************************************
    // Line sampling and bus conditions
    // ****************************************************************
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Core clock far exceeds either bus rate, so plain edge compare suffices
    assign scl_rise = scl_in && !scl_q; // RL2
    assign scl_fall = !scl_in && scl_q;
    assign start_det = scl_in && scl_q && sda_q && !sda_in;
    assign stop_det = scl_in && scl_q && !sda_q && sda_in;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] rw_q [0:15];
    logic [15:0] result_q;
    logic [7:0] status_q;
    logic [4:0] ptr_q;
    logic incr_q;
    logic [7:0] rd_byte;

    assign function_enable = rw_q[OFS_FUNCTION_ENABLE[3:0]];
    assign ambient_conversion_time = rw_q[OFS_AMBIENT_CONVERSION_TIME[3:0]];
    assign prox_conversion_time = rw_q[OFS_PROX_CONVERSION_TIME[3:0]];
    assign idle_period_length = rw_q[OFS_IDLE_PERIOD_LENGTH[3:0]];
    assign prox_lower_limit = {rw_q[OFS_PROX_LOWER_LIMIT_HI[3:0]], rw_q[OFS_PROX_LOWER_LIMIT_LO[3:0]]}; // RL11
    assign prox_upper_limit = {rw_q[OFS_PROX_UPPER_LIMIT_HI[3:0]], rw_q[OFS_PROX_UPPER_LIMIT_LO[3:0]]}; // RL11
    assign interrupt_persistence_filter = rw_q[OFS_INTERRUPT_PERSISTENCE_FILTER[3:0]];
    assign device_configuration = rw_q[OFS_DEVICE_CONFIGURATION[3:0]];
    assign led_pulse_count = rw_q[OFS_LED_PULSE_COUNT[3:0]];
    assign drive_control = rw_q[OFS_DRIVE_CONTROL[3:0]];

    // Unmapped offsets read as zero
    always_comb begin
        if (srap_is_rw(ptr_q)) begin
            rd_byte = rw_q[ptr_q[3:0]];
        end else begin
            case (ptr_q)
                OFS_PART_IDENTITY: rd_byte = SRAP_PART_ID;
                OFS_DEVICE_STATUS: rd_byte = status_q;
                OFS_PROX_RESULT_LO: rd_byte = result_q[7:0]; // RL12
                OFS_PROX_RESULT_HI: rd_byte = result_q[15:8]; // RL12
                default: rd_byte = RST_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // Byte protocol engine
    // ****************************************************************
    srap_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic rw_bit_q;
    logic first_q;
    logic mack_q;
    logic sda_oe_q;
    logic sda_out_q;
    logic clr_q;
    logic byte_done;
    logic wr_byte;
    logic cmd_byte;
    logic data_byte;
    logic rd_load;
    logic [1:0] cmd_type;

    assign sda_oe = sda_oe_q;
    assign sda_out = sda_out_q;
    assign prox_int_clear = clr_q;

    assign byte_done = scl_fall && (cnt_q == SLOT_BYTE_DONE);
    assign wr_byte = byte_done && (state_q == ST_WRITE);
    assign cmd_byte = wr_byte && first_q && shift_q[CMD_SELECT_BIT]; // RL3
    assign data_byte = wr_byte && !(first_q && shift_q[CMD_SELECT_BIT]); // RL6
    assign cmd_type = shift_q[CMD_TYPE_HI:CMD_TYPE_LO];
    assign rd_load = scl_fall && (cnt_q == SLOT_ACK) &&
                     ((state_q == ST_ADDR && rw_bit_q) || (state_q == ST_READ && mack_q));

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            cnt_q <= SLOT_FIRST;
            shift_q <= RST_ZERO;
            tx_q <= RST_ZERO;
            rw_bit_q <= 1'b0;
            first_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else if (start_det) begin
            // Repeated start lands here too; pointer is kept
            state_q <= ST_ADDR; // RL4
            cnt_q <= SLOT_FIRST;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            cnt_q <= SLOT_FIRST;
            sda_oe_q <= 1'b0;
        end else if (state_q != ST_IDLE) begin
            if (scl_rise && cnt_q != SLOT_ACK) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q <= SLOT_LAST_DATA) begin
                    shift_q <= {shift_q[6:0], sda_in};
                end else begin
                    mack_q <= !sda_in;
                end
            end
            if (scl_fall) begin
                case (cnt_q)
                    SLOT_BYTE_DONE: begin
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == SRAP_TARGET_ADDR) begin // RL1
                                sda_oe_q <= 1'b1;
                                rw_bit_q <= shift_q[0];
                            end else begin
                                state_q <= ST_IDLE;
                                cnt_q <= SLOT_FIRST;
                            end
                        end else if (state_q == ST_WRITE) begin
                            sda_oe_q <= 1'b1;
                            first_q <= 1'b0;
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                    SLOT_ACK: begin
                        cnt_q <= SLOT_FIRST;
                        if (rd_load) begin
                            state_q <= ST_READ; // RL5
                            tx_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                        end else if (state_q == ST_ADDR) begin
                            state_q <= ST_WRITE;
                            first_q <= 1'b1; // RL3
                            sda_oe_q <= 1'b0;
                        end else if (state_q == ST_READ) begin
                            // Host refused the byte: stay off the bus until the next start
                            state_q <= ST_IDLE;
                            sda_oe_q <= 1'b0;
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                    default: begin
                        if (state_q == ST_READ && cnt_q != SLOT_FIRST) begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= !tx_q[6];
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Pointer and command decode
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ptr_q <= RST_POINTER;
            incr_q <= 1'b0;
        end else if (cmd_byte) begin
            // Reserved type 10 is ignored; special type leaves the pointer alone
            if (cmd_type == TYPE_REPEAT || cmd_type == TYPE_AUTO_INC) begin
                ptr_q <= shift_q[CMD_ADDR_HI:0]; // RL7
                incr_q <= (cmd_type == TYPE_AUTO_INC); // RL15
            end
        end else if ((data_byte || rd_load) && incr_q) begin
            ptr_q <= ptr_q + 5'h01; // RL15
        end
    end

    // Action pulse lasts one cycle, so nothing needs to clear it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= cmd_byte && (cmd_type == TYPE_SPECIAL) &&
                     (shift_q[CMD_ADDR_HI:0] == SF_PROX_INT_CLEAR); // RL8 RL16
        end
    end

    // ****************************************************************
    // Register writes and captured state
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) begin
                rw_q[i] <= srap_reset_value(5'(i)); // RL13
            end
        end else if (data_byte && srap_is_rw(ptr_q)) begin
            rw_q[ptr_q[3:0]] <= shift_q; // RL6
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            result_q <= 16'h0000; // RL12
            status_q <= RST_ZERO;
        end else begin
            status_q <= device_status;
            if (prox_result_valid) begin
                result_q <= prox_result;
            end
        end
    end

endmodule : srap_i2c_target

// >>> hw/srap_pkg.sv
package srap_pkg;

    // ****************************************************************
    // Bus identity
    // ****************************************************************
    // Target address value is arbitrary and should be set per product
    localparam logic [6:0] SRAP_TARGET_ADDR = 7'h2A;
    // Part identity value is arbitrary
    localparam logic [7:0] SRAP_PART_ID = 8'hA5;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [4:0] OFS_FUNCTION_ENABLE = 5'h00;
    localparam logic [4:0] OFS_AMBIENT_CONVERSION_TIME = 5'h01;
    localparam logic [4:0] OFS_PROX_CONVERSION_TIME = 5'h02;
    localparam logic [4:0] OFS_IDLE_PERIOD_LENGTH = 5'h03;
    localparam logic [4:0] OFS_PROX_LOWER_LIMIT_LO = 5'h08;
    localparam logic [4:0] OFS_PROX_LOWER_LIMIT_HI = 5'h09;
    localparam logic [4:0] OFS_PROX_UPPER_LIMIT_LO = 5'h0A;
    localparam logic [4:0] OFS_PROX_UPPER_LIMIT_HI = 5'h0B;
    localparam logic [4:0] OFS_INTERRUPT_PERSISTENCE_FILTER = 5'h0C;
    localparam logic [4:0] OFS_DEVICE_CONFIGURATION = 5'h0D;
    localparam logic [4:0] OFS_LED_PULSE_COUNT = 5'h0E;
    localparam logic [4:0] OFS_DRIVE_CONTROL = 5'h0F;
    localparam logic [4:0] OFS_PART_IDENTITY = 5'h12;
    localparam logic [4:0] OFS_DEVICE_STATUS = 5'h13;
    localparam logic [4:0] OFS_PROX_RESULT_LO = 5'h18;
    localparam logic [4:0] OFS_PROX_RESULT_HI = 5'h19;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_FUNCTION_ENABLE = 8'h00;
    localparam logic [7:0] RST_PROX_CONVERSION_TIME = 8'hFF;
    localparam logic [7:0] RST_IDLE_PERIOD_LENGTH = 8'hFF;
    localparam logic [4:0] RST_POINTER = 5'h00;

    // ****************************************************************
    // Command byte layout
    // ****************************************************************
    localparam int CMD_SELECT_BIT = 7;
    localparam int CMD_TYPE_HI = 6;
    localparam int CMD_TYPE_LO = 5;
    localparam int CMD_ADDR_HI = 4;
    localparam logic [1:0] TYPE_REPEAT = 2'h0;
    localparam logic [1:0] TYPE_AUTO_INC = 2'h1;
    localparam logic [1:0] TYPE_SPECIAL = 2'h3;
    localparam logic [4:0] SF_PROX_INT_CLEAR = 5'h05;

    // ****************************************************************
    // Bit slot counts
    // ****************************************************************
    localparam logic [3:0] SLOT_FIRST = 4'h0;
    localparam logic [3:0] SLOT_LAST_DATA = 4'h7;
    localparam logic [3:0] SLOT_BYTE_DONE = 4'h8;
    localparam logic [3:0] SLOT_ACK = 4'h9;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WRITE = 2'b10,
        ST_READ = 2'b11
    } srap_state_e;

    function automatic logic srap_is_rw(input logic [4:0] ofs);
        srap_is_rw = (ofs <= OFS_IDLE_PERIOD_LENGTH) ||
                     (ofs >= OFS_PROX_LOWER_LIMIT_LO && ofs <= OFS_DRIVE_CONTROL);
    endfunction : srap_is_rw

    function automatic logic [7:0] srap_reset_value(input logic [4:0] ofs);
        case (ofs)
            OFS_FUNCTION_ENABLE: srap_reset_value = RST_FUNCTION_ENABLE;
            OFS_PROX_CONVERSION_TIME: srap_reset_value = RST_PROX_CONVERSION_TIME;
            OFS_IDLE_PERIOD_LENGTH: srap_reset_value = RST_IDLE_PERIOD_LENGTH;
            default: srap_reset_value = RST_ZERO;
        endcase
    endfunction : srap_reset_value

endpackage : srap_pkg

// >>> verif/sensor_register_access_port_bench.sv
module sensor_register_access_port_bench import srap_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic prox_result_valid = 1'b0;
    logic [15:0] prox_result = 16'h0000;
    logic [7:0] device_status = 8'h3C;
    logic scl_in, sda_in, sda_out, sda_oe, prox_int_clear, a;
    logic [7:0] fe, act, pct, ipl, ipf, dcf, lpc, dct, q;
    logic [15:0] pll, pul;
    int errors = 0;
    int n_checks = 0;
    int clears = 0;
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (prox_int_clear === 1'b1) clears++;
    srap_i2c_target i_srap_i2c_target (.core_clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe,
        .prox_result, .prox_result_valid, .device_status, .function_enable(fe), .ambient_conversion_time(act),
        .prox_conversion_time(pct), .idle_period_length(ipl), .prox_lower_limit(pll), .prox_upper_limit(pul),
        .interrupt_persistence_filter(ipf), .device_configuration(dcf), .led_pulse_count(lpc),
        .drive_control(dct), .prox_int_clear);
    srap_host_model i_srap_host_model (.core_clk, .sda_oe, .scl_in, .sda_in);
    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task put(input logic [7:0] b, input logic ea);
        i_srap_host_model.xfer(b, 1'b1, q, a);
        chk("ack", ea, a === 1'b0);
    endtask : put
    task get(input logic [7:0] e, input logic last);
        i_srap_host_model.xfer(8'hFF, last, q, a);
        chk("read", e, q);
    endtask : get
    task aw;
        i_srap_host_model.start;
        put({SRAP_TARGET_ADDR, 1'b0}, 1'b1);
    endtask : aw
    task ar;
        i_srap_host_model.start;
        put({SRAP_TARGET_ADDR, 1'b1}, 1'b1);
    endtask : ar
    task wr(input logic [7:0] cmd, input logic [7:0] d);
        aw;
        put(cmd, 1'b1);
        put(d, 1'b1);
        i_srap_host_model.stop;
    endtask : wr
    function automatic logic [7:0] exp_rst(input int o);
        case (o)
            2, 3: exp_rst = 8'hFF;
            18: exp_rst = SRAP_PART_ID;
            19: exp_rst = device_status;
            default: exp_rst = 8'h00;
        endcase
    endfunction : exp_rst
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge core_clk);
        #1 reset_n = 1'b1;
        aw;
        put(8'hA0, 1'b1);
        ar;
        for (int i = 0; i < 32; i++) get(exp_rst(i), i == 31);
        i_srap_host_model.stop;
        chk("prox time", 16'h00FF, pct);
        chk("idle", 16'h00FF, ipl);
        chk("persist", 16'h0000, ipf);
        chk("config", 16'h0000, dcf);
        i_srap_host_model.start;
        put({SRAP_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b0);
        i_srap_host_model.stop;
        // Fast-mode bit rate on the threshold burst
        i_srap_host_model.half = 125;
        aw;
        put(8'hA8, 1'b1);
        for (int i = 1; i < 5; i++) put(8'h11 * i, 1'b1);
        i_srap_host_model.stop;
        i_srap_host_model.half = 10;
        chk("lower", 16'h2211, pll);
        chk("upper", 16'h4433, pul);
        aw;
        put(8'h8E, 1'b1);
        put(8'h5A, 1'b1);
        put(8'h6B, 1'b1);
        i_srap_host_model.stop;
        chk("pulse", 8'h6B, lpc);
        chk("drive", 8'h00, dct);
        ar;
        get(8'h6B, 1'b0);
        get(8'h6B, 1'b1);
        i_srap_host_model.stop;
        aw;
        put(8'h3C, 1'b1);
        i_srap_host_model.stop;
        chk("pulse", 8'h3C, lpc);
        prox_result = 16'hBEEF;
        prox_result_valid = 1'b1;
        i_srap_host_model.tick(1);
        prox_result_valid = 1'b0;
        wr(8'h98, 8'h77);
        aw;
        put(8'hB8, 1'b1);
        ar;
        get(8'hEF, 1'b0);
        get(8'hBE, 1'b1);
        i_srap_host_model.stop;
        wr(8'h81, 8'hFF);
        chk("ambient", 8'hFF, act);
        wr(8'h80, 8'h25);
        chk("enable", 8'h25, fe);
        aw;
        put(8'hE0, 1'b1);
        i_srap_host_model.stop;
        aw;
        put(8'hE5, 1'b1);
        i_srap_host_model.stop;
        chk("clears", 16'h0001, clears[15:0]);
        final_report;
    end
endmodule : sensor_register_access_port_bench

// >>> verif/srap_host_model.sv
module srap_host_model (
    input wire logic core_clk,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 10;
    logic sda_rel = 1'b1;
    // Released line floats high through the pull-up
    assign sda_in = sda_rel & ~sda_oe;
    initial scl_in = 1'b1;
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // Data moves two cycles after the clock falls so no false start or stop is seen
    task start;
        tick(2);
        sda_rel = 1'b1;
        tick(half);
        scl_in = 1'b1;
        tick(half);
        sda_rel = 1'b0;
        tick(half);
        scl_in = 1'b0;
    endtask : start
    task stop;
        tick(2);
        sda_rel = 1'b0;
        tick(half);
        scl_in = 1'b1;
        tick(half);
        sda_rel = 1'b1;
        tick(half);
    endtask : stop
    task bit_io(input logic b, output logic r);
        tick(2);
        sda_rel = b;
        tick(half);
        scl_in = 1'b1;
        tick(half);
        r = sda_in;
        scl_in = 1'b0;
    endtask : bit_io
    task xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, a);
    endtask : xfer
endmodule : srap_host_model

// >>> verif/srap_i2c_target_sva.sv
module srap_i2c_target_sva (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [7:0] function_enable,
    input wire logic [7:0] prox_conversion_time,
    input wire logic [7:0] idle_period_length,
    input wire logic [7:0] led_pulse_count,
    input wire logic [15:0] prox_lower_limit,
    input wire logic [15:0] prox_upper_limit,
    input wire logic prox_int_clear
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda drive value not zero");
    a_reset_regs: assert property ($rose(reset_n) |-> function_enable == 8'h00 && !sda_oe
        && prox_conversion_time == 8'hFF && idle_period_length == 8'hFF && prox_lower_limit == 16'h0000)
        else $error("register not at reset value");
    a_clear_one_cycle: assert property (prox_int_clear |=> !prox_int_clear)
        else $error("interrupt clear longer than one cycle");
    a_clear_in_ack: assert property (prox_int_clear |-> sda_oe && !scl_in)
        else $error("interrupt clear outside acknowledge");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("sda drive changed while clock high");
    a_lower_one_byte: assert property ($changed(prox_lower_limit)
        |-> $stable(prox_lower_limit[15:8]) || $stable(prox_lower_limit[7:0]))
        else $error("both lower threshold bytes changed at once");
    a_upper_one_byte: assert property ($changed(prox_upper_limit)
        |-> $stable(prox_upper_limit[15:8]) || $stable(prox_upper_limit[7:0]))
        else $error("both upper threshold bytes changed at once");
    a_write_at_ack: assert property ($changed(function_enable) || $changed(led_pulse_count)
        |-> sda_oe && !scl_in)
        else $error("register written outside acknowledge");
endmodule : srap_i2c_target_sva

bind srap_i2c_target srap_i2c_target_sva i_srap_i2c_target_sva (.core_clk, .reset_n, .scl_in, .sda_out,
    .sda_oe, .function_enable, .prox_conversion_time, .idle_period_length, .led_pulse_count,
    .prox_lower_limit, .prox_upper_limit, .prox_int_clear);
